// ---- inc/canmc_pkg.sv ----
package canmc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OFS_CTL_SECOND = 8'h00;
  localparam logic [7:0] OFS_CTL_FIRST  = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;

  // control_reg_second fields
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_CLOCK_SOURCE_SELECT   = 6;
  localparam int BIT_LOOPBACK = 5;
  localparam int BIT_LISTEN   = 4;
  localparam int BIT_WFILTER  = 2;
  localparam int BIT_SLP_ACK  = 1;
  localparam int BIT_INIT_ACK = 0;

  // control_reg_first fields
  localparam int BIT_WAKE_EN  = 2;
  localparam int BIT_SLP_REQ  = 1;
  localparam int BIT_INIT_REQ = 0;

  // status fields
  localparam int BIT_ST_SYNCED  = 2;
  localparam int BIT_ST_BUS_OFF = 1;
  localparam int BIT_ST_RX_BUSY = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_CTL_SECOND = 8'h00;
  localparam logic [7:0] RST_CTL_FIRST  = 8'h01;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS        = 40;
  localparam int WAKE_FILTER_NS       = 2000;
  localparam int WAKE_FILTER_CYC      = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESYNC_RECESSIVE_BITS = 11;
  localparam int RESYNC_BUSOFF_RUNS    = 128;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {RS_HALT, RS_HUNT, RS_RUN} canmc_sync_t;
endpackage

// ---- hdl/canmc_sync3.sv ----
`timescale 1ns/1ns
module canmc_sync3 #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic s1_q, s2_q, s3_q, out_q;
  logic out_d;

  // a change counts only once the second and third stage agree
  always_comb begin
    out_d = out_q;
    if (s2_q == s3_q) begin
      out_d = s3_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q  <= RESET_LEVEL;
      s2_q  <= RESET_LEVEL;
      s3_q  <= RESET_LEVEL;
      out_q <= RESET_LEVEL;
    end else begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ---- hdl/canmc_wake_filter.sv ----
`timescale 1ns/1ns
module canmc_wake_filter #(
  parameter int MIN_CYC = 50
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic dominant,
  output logic      long_pulse
);
  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_CYC);

  logic [CW-1:0] cnt_q, cnt_d;

  // glitches shorter than the filter time restart the count
  always_comb begin
    cnt_d = '0;
    if (dominant) begin
      cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign long_pulse = (cnt_q == CNT_MAX);
endmodule

// ---- hdl/canmc_top.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// - register always readable, written only in init
// - enable bit write-once normal, free special
// - bit 6 picks oscillator or bus clock
// - loopback feeds transmit stream into receiver
// - loopback ignores receive pin, transmit recessive
// - loopback ignores acknowledge slot bit
// - loopback still raises transmit and receive interrupts
// - listen-only receives, never drives ack or error
// - listen-only freezes error counters
// - listen-only starts no transmission
// - wake filter select: any dominant or long pulse
// - bit 1 sleep acknowledge, sleep needs both
// - wake on bus activity clears sleep acknowledge
// - bit 0 init acknowledge, init needs both
// - timing and filter registers written only in init
// - sleep entered only when bus idle
// - init request aborts traffic, then acknowledge
// - wake enable decides if traffic ends sleep
// - resync after 11 recessive, bus-off 128 times
module canmc_top #(
  parameter int WAKE_CYC = canmc_pkg::WAKE_FILTER_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SPECIAL_MODE,
  input  wire logic        BUS_RECEIVE_PIN,
  output logic             BUS_TRANSMIT_PIN,
  input  wire logic        ENG_TX_BIT,
  input  wire logic        ENG_TX_REQ,
  input  wire logic        ENG_ERRCNT_STEP,
  input  wire logic        ENG_TX_DONE,
  input  wire logic        ENG_RX_DONE,
  input  wire logic        ENG_RECEIVING,
  input  wire logic        ENG_TX_EMPTY,
  input  wire logic        ENG_BUS_OFF,
  input  wire logic        ENG_BIT_TICK,
  output logic             ENG_RX_BIT,
  output logic             ENG_ACK_IGNORE,
  output logic             ENG_DRIVE_ALLOW,
  output logic             ENG_TX_START,
  output logic             ENG_ERRCNT_EN,
  output logic             ENG_ABORT,
  output logic             ENG_SYNCED,
  output logic             TX_DONE_IRQ,
  output logic             RX_DONE_IRQ,
  output logic             MODULE_ENABLE,
  output logic             CLOCK_SOURCE_BUS,
  output logic             TIMING_WRITE_EN
);
  import canmc_pkg::*;

  // ****************************************************************
  // pin input conditioning
  // ****************************************************************
  logic rx_pin_s, rx_long;

  canmc_sync3 #(.RESET_LEVEL(1'b1)) u_rx_sync (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .din   (BUS_RECEIVE_PIN),
    .dout  (rx_pin_s)
  );

  canmc_wake_filter #(.MIN_CYC(WAKE_CYC)) u_wake_filter (
    .clk        (CLOCK),
    .rst_b      (RST_B),
    .dominant   (~rx_pin_s),
    .long_pulse (rx_long)
  );

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [7:0]  w_byte_q, w_byte_d;
  logic        w_lane_q, w_lane_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_fire;
  logic [7:0]  rd_val;
  logic        rd_hit;

  assign AWREADY = ~aw_hold_q & ~bvalid_q;
  assign WREADY  = ~w_hold_q & ~bvalid_q;
  assign ARREADY = ~rvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign RVALID  = rvalid_q;
  assign RRESP   = rresp_q;
  assign RDATA   = rdata_q;

  // address and data are taken in either order, the write fires once both are held
  assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;

  // ****************************************************************
  // control state
  // ****************************************************************
  logic enable_q, enable_d, en_written_q, en_written_d;
  logic clock_source_select_q, clock_source_select_d, loop_q, loop_d, listen_q, listen_d;
  logic wfilt_q, wfilt_d, slp_ack_q, slp_ack_d, init_ack_q, init_ack_d;
  logic wake_en_q, wake_en_d, slp_req_q, slp_req_d, init_req_q, init_req_d;
  logic init_mode, sleep_mode, wake_evt, bus_idle;
  logic wr_second, wr_first;

  assign init_mode  = init_req_q & init_ack_q;
  assign sleep_mode = slp_req_q & slp_ack_q;
  assign bus_idle   = ~ENG_RECEIVING & ENG_TX_EMPTY;
  assign wr_second  = wr_fire & (aw_addr_q == OFS_CTL_SECOND) & w_lane_q;
  assign wr_first   = wr_fire & (aw_addr_q == OFS_CTL_FIRST) & w_lane_q;
  // filter select picks raw dominant level or the long-pulse detector
  assign wake_evt   = wfilt_q ? rx_long : ~rx_pin_s;

  always_comb begin
    rd_hit = 1'b1;
    unique case (ARADDR)
      OFS_CTL_SECOND: rd_val = {enable_q, clock_source_select_q, loop_q, listen_q, 1'b0,
                                wfilt_q, slp_ack_q, init_ack_q};
      OFS_CTL_FIRST:  rd_val = {5'h0, wake_en_q, slp_req_q, init_req_q};
      OFS_STATUS:     rd_val = {5'h0, ENG_SYNCED, ENG_BUS_OFF, ENG_RECEIVING};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    aw_hold_d = aw_hold_q;
    aw_addr_d = aw_addr_q;
    w_hold_d  = w_hold_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (AWVALID && AWREADY) begin
      aw_hold_d = 1'b1;
      aw_addr_d = {AWADDR[7:2], 2'b00};
    end
    if (WVALID && WREADY) begin
      w_hold_d = 1'b1;
      w_byte_d = WDATA[7:0];
      w_lane_d = WSTRB[0];
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_addr_q == OFS_CTL_SECOND || aw_addr_q == OFS_CTL_FIRST ||
                   aw_addr_q == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h00_0000, rd_val};
      rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_hold_q <= aw_hold_d;
      aw_addr_q <= aw_addr_d;
      w_hold_q  <= w_hold_d;
      w_byte_q  <= w_byte_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // ****************************************************************
  // mode handshakes and control register
  // ****************************************************************
  always_comb begin
    enable_d     = enable_q;
    en_written_d = en_written_q;
    clock_source_select_d     = clock_source_select_q;
    loop_d       = loop_q;
    listen_d     = listen_q;
    wfilt_d      = wfilt_q;
    wake_en_d    = wake_en_q;
    slp_req_d    = slp_req_q;
    init_req_d   = init_req_q;
    // writes to control_reg_second outside init mode are dropped silently
    if (wr_second && init_mode) begin
      clock_source_select_d = w_byte_q[BIT_CLOCK_SOURCE_SELECT];
      loop_d   = w_byte_q[BIT_LOOPBACK];
      listen_d = w_byte_q[BIT_LISTEN];
      wfilt_d  = w_byte_q[BIT_WFILTER];
      if (SPECIAL_MODE || !en_written_q) begin
        enable_d     = w_byte_q[BIT_ENABLE];
        en_written_d = 1'b1;
      end
    end
    if (wr_first) begin
      wake_en_d = w_byte_q[BIT_WAKE_EN];
      // a request cannot be withdrawn before its acknowledge arrived
      if (w_byte_q[BIT_INIT_REQ] || init_ack_q) begin
        init_req_d = w_byte_q[BIT_INIT_REQ];
      end
      if (w_byte_q[BIT_SLP_REQ] || slp_ack_q) begin
        slp_req_d = w_byte_q[BIT_SLP_REQ];
      end
    end
    // bus activity ends sleep only with wake enabled; the hardware clear wins over a write
    if (sleep_mode && wake_en_q && wake_evt) begin
      slp_req_d = 1'b0;
    end
    // init ack follows the request one cycle later; abort is already active meanwhile
    init_ack_d = init_req_q;
    slp_ack_d  = slp_ack_q;
    if (!slp_req_q) begin
      slp_ack_d = 1'b0;
    end else if (slp_ack_q && wake_en_q && wake_evt) begin
      slp_ack_d = 1'b0;
    end else if (!slp_ack_q && bus_idle && !wake_evt) begin
      slp_ack_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      enable_q     <= RST_CTL_SECOND[BIT_ENABLE];
      en_written_q <= 1'b0;
      clock_source_select_q     <= RST_CTL_SECOND[BIT_CLOCK_SOURCE_SELECT];
      loop_q       <= RST_CTL_SECOND[BIT_LOOPBACK];
      listen_q     <= RST_CTL_SECOND[BIT_LISTEN];
      wfilt_q      <= RST_CTL_SECOND[BIT_WFILTER];
      slp_ack_q    <= RST_CTL_SECOND[BIT_SLP_ACK];
      init_ack_q   <= RST_CTL_SECOND[BIT_INIT_ACK];
      wake_en_q    <= RST_CTL_FIRST[BIT_WAKE_EN];
      slp_req_q    <= RST_CTL_FIRST[BIT_SLP_REQ];
      init_req_q   <= RST_CTL_FIRST[BIT_INIT_REQ];
    end else begin
      enable_q     <= enable_d;
      en_written_q <= en_written_d;
      clock_source_select_q     <= clock_source_select_d;
      loop_q       <= loop_d;
      listen_q     <= listen_d;
      wfilt_q      <= wfilt_d;
      slp_ack_q    <= slp_ack_d;
      init_ack_q   <= init_ack_d;
      wake_en_q    <= wake_en_d;
      slp_req_q    <= slp_req_d;
      init_req_q   <= init_req_d;
    end
  end

  // ****************************************************************
  // bus resynchronisation after init
  // ****************************************************************
  canmc_sync_t rs_q, rs_d;
  logic [3:0]  rec_cnt_q, rec_cnt_d;
  logic [7:0]  run_cnt_q, run_cnt_d;

  always_comb begin
    rs_d      = rs_q;
    rec_cnt_d = rec_cnt_q;
    run_cnt_d = run_cnt_q;
    if (init_req_q) begin
      rs_d      = RS_HALT;
      rec_cnt_d = 4'h0;
      run_cnt_d = 8'h00;
    end else begin
      unique case (rs_q)
        RS_HALT: rs_d = RS_HUNT;
        RS_HUNT: begin
          if (ENG_BIT_TICK) begin
            if (!ENG_RX_BIT) begin
              rec_cnt_d = 4'h0;
            end else if (rec_cnt_q == 4'(RESYNC_RECESSIVE_BITS - 1)) begin
              rec_cnt_d = 4'h0;
              if (!ENG_BUS_OFF || run_cnt_q == 8'(RESYNC_BUSOFF_RUNS - 1)) begin
                rs_d = RS_RUN;
              end else begin
                run_cnt_d = run_cnt_q + 8'h01;
              end
            end else begin
              rec_cnt_d = rec_cnt_q + 4'h1;
            end
          end
        end
        RS_RUN: rs_d = RS_RUN;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rs_q      <= RS_HALT;
      rec_cnt_q <= 4'h0;
      run_cnt_q <= 8'h00;
    end else begin
      rs_q      <= rs_d;
      rec_cnt_q <= rec_cnt_d;
      run_cnt_q <= run_cnt_d;
    end
  end

  // ****************************************************************
  // datapath steering to engine and pins
  // ****************************************************************
  logic tx_pin_q, tx_pin_d, rx_bit_q, rx_bit_d, txirq_q, rxirq_q;
  logic quiet;

  // transmit goes recessive one cycle after the init request register sets so no frame is cut dominant
  assign quiet = loop_q | listen_q | init_req_q | ~enable_q | sleep_mode;

  always_comb begin
    tx_pin_d = quiet ? 1'b1 : ENG_TX_BIT;
    rx_bit_d = loop_q ? ENG_TX_BIT : rx_pin_s;
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tx_pin_q <= 1'b1;
      rx_bit_q <= 1'b1;
      txirq_q  <= 1'b0;
      rxirq_q  <= 1'b0;
    end else begin
      tx_pin_q <= tx_pin_d;
      rx_bit_q <= rx_bit_d;
      txirq_q  <= ENG_TX_DONE;
      rxirq_q  <= ENG_RX_DONE;
    end
  end

  assign BUS_TRANSMIT_PIN = tx_pin_q;
  assign ENG_RX_BIT       = rx_bit_q;
  assign ENG_ACK_IGNORE   = loop_q;
  assign ENG_DRIVE_ALLOW  = ~listen_q;
  assign ENG_TX_START     = ENG_TX_REQ & ~listen_q & ~init_req_q & enable_q;
  assign ENG_ERRCNT_EN    = ENG_ERRCNT_STEP & ~listen_q;
  assign ENG_ABORT        = init_req_q;
  assign ENG_SYNCED       = (rs_q == RS_RUN);
  assign TX_DONE_IRQ      = txirq_q;
  assign RX_DONE_IRQ      = rxirq_q;
  assign MODULE_ENABLE    = enable_q;
  assign CLOCK_SOURCE_BUS = clock_source_select_q;
  assign TIMING_WRITE_EN  = init_mode;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_ctl_locked;
    @(posedge CLOCK) disable iff (!RST_B)
      (!init_mode && !$past(init_mode)) |=> $stable(loop_q) && $stable(listen_q) && $stable(clock_source_select_q);
  endproperty
  a_ctl_locked: assert property (p_ctl_locked) else $error("control changed outside init");

  property p_enable_once;
    @(posedge CLOCK) disable iff (!RST_B)
      (en_written_q && !SPECIAL_MODE) |=> $stable(enable_q);
  endproperty
  a_enable_once: assert property (p_enable_once) else $error("enable rewritten in normal mode");

  property p_loop_tx;
    @(posedge CLOCK) disable iff (!RST_B)
      loop_q ##1 loop_q |-> BUS_TRANSMIT_PIN;
  endproperty
  a_loop_tx: assert property (p_loop_tx) else $error("transmit pin dominant in loopback");

  property p_loop_rx;
    @(posedge CLOCK) disable iff (!RST_B)
      loop_q |=> ENG_RX_BIT == $past(ENG_TX_BIT);
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loopback stream not fed back");

  property p_listen_quiet;
    @(posedge CLOCK) disable iff (!RST_B)
      listen_q |-> !ENG_TX_START && !ENG_ERRCNT_EN && !ENG_DRIVE_ALLOW;
  endproperty
  a_listen_quiet: assert property (p_listen_quiet) else $error("listen-only drove or counted");

  property p_init_ack;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(init_req_q) |=> init_ack_q;
  endproperty
  a_init_ack: assert property (p_init_ack) else $error("init ack late");

  property p_sleep_idle;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(slp_ack_q) |-> $past(bus_idle) && $past(slp_req_q);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered while busy");

  property p_wake_clear;
    @(posedge CLOCK) disable iff (!RST_B)
      (sleep_mode && wake_en_q && wake_evt) |=> !slp_ack_q ##1 !slp_ack_q;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("sleep ack kept after wake");

  property p_no_wake;
    @(posedge CLOCK) disable iff (!RST_B)
      (sleep_mode && !wake_en_q && !wr_first) |=> slp_ack_q;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("woke with wake disabled");

  property p_resync;
    @(posedge CLOCK) disable iff (!RST_B)
      $rose(ENG_SYNCED) |-> $past(rec_cnt_q) == 4'(RESYNC_RECESSIVE_BITS - 1);
  endproperty
  a_resync: assert property (p_resync) else $error("resync before recessive run");

  property p_bit3_zero;
    @(posedge CLOCK) disable iff (!RST_B)
      (ARVALID && ARREADY && ARADDR == OFS_CTL_SECOND) |=> RDATA[3] == 1'b0;
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("bit 3 read nonzero");
endmodule

// ---- dv/canmc_bus_node.sv ----
`timescale 1ns/1ns
// ****************************************************************
// remote bus node: holds the bus dominant for a commanded span
// ****************************************************************
module canmc_bus_node (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            rx_pin
);
  logic [7:0] left_q;
  logic [7:0] left_d;

  always_comb begin
    left_d = left_q;
    if (go) begin
      left_d = len;
    end else if (left_q != 8'h00) begin
      left_d = left_q - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 8'h00;
    end else begin
      left_q <= left_d;
    end
  end

  // the bus rests recessive whenever no node pulls it dominant
  assign rx_pin = (left_q == 8'h00);
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import canmc_pkg::*;
  logic        CLOCK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, SPECIAL_MODE, AWREADY, WREADY;
  logic        BVALID, ARREADY, RVALID, BUS_RECEIVE_PIN, BUS_TRANSMIT_PIN, ENG_TX_BIT, ENG_TX_REQ;
  logic        ENG_ERRCNT_STEP, ENG_TX_DONE, ENG_RX_DONE, ENG_RECEIVING, ENG_BIT_TICK, ENG_RX_BIT;
  logic        ENG_ACK_IGNORE, ENG_DRIVE_ALLOW, ENG_TX_START, ENG_ERRCNT_EN, ENG_ABORT, ENG_SYNCED;
  logic        TX_DONE_IRQ, RX_DONE_IRQ, MODULE_ENABLE, CLOCK_SOURCE_BUS, TIMING_WRITE_EN, node_go;
  logic        ENG_TX_EMPTY, ENG_BUS_OFF;
  logic [7:0]  AWADDR, ARADDR, node_len;
  logic [31:0] WDATA, RDATA;
  logic [1:0]  BRESP, RRESP;
  logic [33:0] exp_q[$];
  int          err_total, tests_run, cyc;

  canmc_top #(.WAKE_CYC(4)) uut (
    .CLOCK(CLOCK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .SPECIAL_MODE(SPECIAL_MODE),
    .BUS_RECEIVE_PIN(BUS_RECEIVE_PIN), .BUS_TRANSMIT_PIN(BUS_TRANSMIT_PIN), .ENG_TX_BIT(ENG_TX_BIT),
    .ENG_TX_REQ(ENG_TX_REQ), .ENG_ERRCNT_STEP(ENG_ERRCNT_STEP), .ENG_TX_DONE(ENG_TX_DONE),
    .ENG_RX_DONE(ENG_RX_DONE), .ENG_RECEIVING(ENG_RECEIVING), .ENG_TX_EMPTY(ENG_TX_EMPTY), .ENG_BUS_OFF(ENG_BUS_OFF),
    .ENG_BIT_TICK(ENG_BIT_TICK), .ENG_RX_BIT(ENG_RX_BIT), .ENG_ACK_IGNORE(ENG_ACK_IGNORE),
    .ENG_DRIVE_ALLOW(ENG_DRIVE_ALLOW), .ENG_TX_START(ENG_TX_START), .ENG_ERRCNT_EN(ENG_ERRCNT_EN),
    .ENG_ABORT(ENG_ABORT), .ENG_SYNCED(ENG_SYNCED), .TX_DONE_IRQ(TX_DONE_IRQ), .RX_DONE_IRQ(RX_DONE_IRQ),
    .MODULE_ENABLE(MODULE_ENABLE), .CLOCK_SOURCE_BUS(CLOCK_SOURCE_BUS), .TIMING_WRITE_EN(TIMING_WRITE_EN)
  );

  canmc_bus_node node (.clk(CLOCK), .rst_b(RST_B), .go(node_go), .len(node_len), .rx_pin(BUS_RECEIVE_PIN));

  // ****************************************************************
  // checking and verdict
  // ****************************************************************
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************************************
  // bus master and stimulus tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge CLOCK);
    AWADDR  <= a;
    WDATA   <= {24'h00_0000, d};
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge CLOCK);
      ta = AWVALID & AWREADY;
      tw = WVALID & WREADY;
      tb = BVALID;
      rs = BRESP;
      @(posedge CLOCK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    chk(rs, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic tr, ta;
    @(posedge CLOCK);
    exp_q.push_back({r, 24'h00_0000, d});
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do begin
      @(negedge CLOCK);
      tr = ARVALID & ARREADY;
      ta = RVALID;
      @(posedge CLOCK);
      if (tr) ARVALID <= 1'b0;
    end while (!ta);
    RREADY <= 1'b0;
  endtask

  // read data are judged where they appear, against the oldest note
  always @(negedge CLOCK) begin
    if (RVALID === 1'b1 && RREADY === 1'b1) begin
      chk({RRESP, RDATA}, exp_q.pop_front());
    end
  end

  task automatic bus_pulse(input logic [7:0] n);
    @(posedge CLOCK);
    node_go  <= 1'b1;
    node_len <= n;
    @(posedge CLOCK);
    node_go <= 1'b0;
    repeat (20) @(posedge CLOCK);
  endtask

  task automatic stream(input logic lb);
    logic b;
    for (int i = 0; i < 8; i++) begin
      b = 1'($urandom);
      @(posedge CLOCK);
      ENG_TX_BIT <= b;
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      chk(ENG_RX_BIT, lb ? b : 1'b1);
      chk({ENG_ACK_IGNORE, BUS_TRANSMIT_PIN}, {lb, lb | b});
      chk({ENG_DRIVE_ALLOW, ENG_TX_START, ENG_ERRCNT_EN}, {3{!lb}});
    end
  endtask

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(58));
    {RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, SPECIAL_MODE, node_go} = 8'h00;
    {ENG_TX_BIT, ENG_TX_REQ, ENG_ERRCNT_STEP, ENG_TX_DONE, ENG_RX_DONE, ENG_RECEIVING, ENG_BIT_TICK} = 7'h00;
    {ENG_BUS_OFF, ENG_TX_EMPTY} = 2'h1;
    {AWADDR, ARADDR, node_len, WDATA} = 56'h00_0000_0000_0000;
    repeat (10) @(posedge CLOCK);
    RST_B <= 1'b1;
    rd(OFS_CTL_SECOND, 8'h01, RESP_OKAY);
    rd(OFS_CTL_FIRST, 8'h01, RESP_OKAY);
    rd(8'h0C, 8'h00, RESP_SLVERR);
    wr(8'h0C, 8'h00, RESP_SLVERR);
    wr(OFS_CTL_SECOND, 8'hFF, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'hF5, RESP_OKAY);
    chk({MODULE_ENABLE, CLOCK_SOURCE_BUS, TIMING_WRITE_EN}, 3'b111);
    wr(OFS_CTL_FIRST, 8'h00, RESP_OKAY);
    wr(OFS_CTL_SECOND, 8'h00, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'hF4, RESP_OKAY);
    chk({ENG_ABORT, TIMING_WRITE_EN}, 2'b00);
    // a dominant bus during loopback must not reach the receiver
    @(posedge CLOCK);
    node_go         <= 1'b1;
    node_len        <= 8'h28;
    ENG_TX_REQ      <= 1'b1;
    ENG_ERRCNT_STEP <= 1'b1;
    @(posedge CLOCK);
    node_go <= 1'b0;
    stream(1'b1);
    @(posedge CLOCK);
    {ENG_TX_DONE, ENG_RX_DONE} <= 2'b11;
    @(posedge CLOCK);
    {ENG_TX_DONE, ENG_RX_DONE} <= 2'b00;
    @(negedge CLOCK);
    chk({TX_DONE_IRQ, RX_DONE_IRQ}, 2'b11);
    wr(OFS_CTL_FIRST, 8'h01, RESP_OKAY);
    chk(ENG_ABORT, 1'b1);
    wr(OFS_CTL_SECOND, 8'h00, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'h81, RESP_OKAY);
    SPECIAL_MODE <= 1'b1;
    wr(OFS_CTL_SECOND, 8'h00, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'h01, RESP_OKAY);
    wr(OFS_CTL_SECOND, 8'h80, RESP_OKAY);
    chk({MODULE_ENABLE, CLOCK_SOURCE_BUS}, 2'b10);
    wr(OFS_CTL_FIRST, 8'h00, RESP_OKAY);
    for (int i = 1; i <= 11; i++) begin
      @(posedge CLOCK);
      ENG_BIT_TICK <= 1'b1;
      @(posedge CLOCK);
      ENG_BIT_TICK <= 1'b0;
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      chk(ENG_SYNCED, i == 11);
    end
    stream(1'b0);
    wr(OFS_CTL_FIRST, 8'h06, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'h82, RESP_OKAY);
    bus_pulse(8'h02);
    rd(OFS_CTL_SECOND, 8'h80, RESP_OKAY);
    rd(OFS_CTL_FIRST, 8'h04, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h02, RESP_OKAY);
    bus_pulse(8'h02);
    rd(OFS_CTL_SECOND, 8'h82, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h00, RESP_OKAY);
    {ENG_RECEIVING, ENG_TX_EMPTY} <= 2'b10;
    wr(OFS_CTL_FIRST, 8'h02, RESP_OKAY);
    rd(OFS_CTL_SECOND, 8'h80, RESP_OKAY);
    {ENG_RECEIVING, ENG_TX_EMPTY} <= 2'b00;
    rd(OFS_CTL_SECOND, 8'h80, RESP_OKAY);
    ENG_TX_EMPTY <= 1'b1;
    rd(OFS_CTL_SECOND, 8'h82, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h01, RESP_OKAY);
    wr(OFS_CTL_SECOND, 8'h84, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h04, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h06, RESP_OKAY);
    bus_pulse(8'h02);
    rd(OFS_CTL_SECOND, 8'h86, RESP_OKAY);
    bus_pulse(8'h08);
    rd(OFS_CTL_SECOND, 8'h84, RESP_OKAY);
    // bus-off needs 128 runs of 11 recessive bits before sync returns
    ENG_BUS_OFF <= 1'b1;
    wr(OFS_CTL_FIRST, 8'h01, RESP_OKAY);
    wr(OFS_CTL_FIRST, 8'h00, RESP_OKAY);
    ENG_BIT_TICK <= 1'b1;
    repeat (1407) @(posedge CLOCK);
    @(negedge CLOCK);
    chk(ENG_SYNCED, 1'b0);
    @(negedge CLOCK);
    chk(ENG_SYNCED, 1'b1);
    give_verdict();
  end
endmodule
